//--- rtl/sap_core.sv
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - fetch four, issue at most five per cycle
// - divide, sqrt, multiply units block re-issue
// - five slots, one instruction each, by class
// - dependent instructions wait for operand availability
// - speculative cached miss sends block read request
// - speculative cache changes are never rolled back
// - uncached accesses only non-speculative, non-block sizes
// - stale-address speculation may request any address
// - speculative store miss refills, marks line dirty
// - speculative fetch state change kept after abort
module sap_core
	import sap_pkg::*;
(
	input  wire logic                   clk_sys,
	input  wire logic                   rst_n,
	// fetch group, slot i in bits [i*4+3:i*4] of fetch_op and [i*5+4:i*5] of fetch_dst, fetch_src
	input  wire logic [FETCH_MAX-1:0]   fetch_valid,
	input  wire logic [FETCH_MAX*4-1:0] fetch_op,
	input  wire logic [FETCH_MAX*5-1:0] fetch_dst,
	input  wire logic [FETCH_MAX*5-1:0] fetch_src,
	output logic [FETCH_MAX-1:0]        fetch_take,
	// completion and speculation
	input  wire logic [NUM_SLOTS-1:0]   done_valid,
	input  wire logic [NUM_SLOTS*5-1:0] done_dst,
	input  wire logic [NUM_SLOTS-1:0]   done_spec,
	input  wire logic                   spec_abort,
	input  wire logic                   spec_commit,
	output logic [NUM_SLOTS-1:0]        issue_slot,
	output logic [NREGS-1:0]            arch_written,
	// memory access from the load/store slot or fetch
	input  wire logic                   mem_req,
	input  wire logic                   mem_is_fetch,
	input  wire logic                   mem_is_store,
	input  wire logic                   mem_spec,
	input  wire logic                   mem_uncached,
	input  wire sap_size_t              mem_size,
	input  wire logic [ADDR_W-1:0]      mem_addr,
	output logic                        mem_ack,
	output logic                        mem_nack,
	// external agent
	output logic                        ext_blk_rd,
	output logic                        ext_wback,
	output logic                        ext_unc,
	output logic                        ext_unc_wr,
	output logic [1:0]                  ext_size,
	output logic [ADDR_W-1:0]           ext_addr,
	input  wire logic                   ext_done,
	input  wire logic                   ext_nack,
	output logic [1:0]                  line_state_out
);

	// ************************************************************
	// operand scoreboard and unit busy counters
	// ************************************************************
	logic [NREGS-1:0]   pending;
	logic [NREGS-1:0]   next_pending;
	logic [3:0]         busy_b;
	logic [3:0]         next_busy_b;
	logic [3:0]         busy_e;
	logic [3:0]         next_busy_e;
	logic [NREGS-1:0]   next_arch;
	logic [FETCH_MAX-1:0] ready;
	logic [FETCH_MAX-1:0] ready_e;
	logic [NUM_SLOTS-1:0] take;
	logic [NUM_SLOTS*2-1:0] which;
	logic [FETCH_MAX-1:0] next_take;
	logic [NUM_SLOTS-1:0] next_issue;
	logic [NUM_SLOTS-1:0] unit_free;

	// operand ready: source and destination not awaiting a result
	always_comb begin
		for (int i = 0; i < FETCH_MAX; i++) begin
			ready[i] = fetch_valid[i]
				&& !pending[fetch_src[i*5 +: 5]]
				&& !pending[fetch_dst[i*5 +: 5]];
			// younger instructions may not bypass an older one that writes their source
			for (int j = 0; j < i; j++) begin
				if (fetch_valid[j] && fetch_dst[j*5 +: 5] == fetch_src[i*5 +: 5])
					ready[i] = 1'b0;
			end
		end
	end

	// unpipelined units stop their slot until the interval runs out
	always_comb begin
		unit_free = '1;
		unit_free[SLOT_B] = (busy_b == BUSY_RESET);
		unit_free[SLOT_E] = (busy_e == BUSY_RESET);
	end

	// add and logic fit two slots; slot E skips the lane slot D took so no lane issues twice
	always_comb begin
		ready_e = ready;
		if (take[SLOT_D])
			ready_e[which[SLOT_D*2 +: 2]] = 1'b0;
	end

	// one selector per slot, so at most five issue per cycle
	for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
		sap_slot_sel #(
			.SLOT(s)
		) u_sel (
			.ops      (fetch_op),
			.ready    ((s == SLOT_E) ? ready_e : ready),
			.unit_free(unit_free[s]),
			.take     (take[s]),
			.which    (which[s*2 +: 2])
		);
	end

	// issue bookkeeping: mark destinations busy, clear on completion
	always_comb begin
		next_pending = pending;
		next_busy_b  = (busy_b != BUSY_RESET) ? busy_b - 4'h1 : busy_b;
		next_busy_e  = (busy_e != BUSY_RESET) ? busy_e - 4'h1 : busy_e;
		next_take    = '0;
		next_issue   = take;
		next_arch    = '0;
		for (int s = 0; s < NUM_SLOTS; s++) begin
			if (done_valid[s]) begin
				next_pending[done_dst[s*5 +: 5]] = 1'b0;
				// speculative results stay in rename space until commit
				if (!done_spec[s] || spec_commit)
					next_arch[done_dst[s*5 +: 5]] = !(done_spec[s] && spec_abort);
			end
		end
		for (int s = 0; s < NUM_SLOTS; s++) begin
			if (take[s]) begin
				next_take[which[s*2 +: 2]] = 1'b1;
				next_pending[fetch_dst[which[s*2 +: 2]*5 +: 5]] = 1'b1;
				case (sap_op_t'(fetch_op[which[s*2 +: 2]*4 +: 4]))
					SAP_OP_FDIV:  next_busy_b = FDIV_INTERVAL;
					SAP_OP_FSQRT: next_busy_b = FSQRT_INTERVAL;
					SAP_OP_IMUL:  next_busy_e = IMUL_INTERVAL;
					SAP_OP_IDIV:  next_busy_e = IDIV_INTERVAL;
					default:      ;
				endcase
			end
		end
		// register zero never waits
		next_pending[0] = 1'b0;
		if (spec_abort)
			next_pending = '0;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pending      <= '0;
			busy_b       <= BUSY_RESET;
			busy_e       <= BUSY_RESET;
			fetch_take   <= '0;
			issue_slot   <= '0;
			arch_written <= '0;
		end else begin
			pending      <= next_pending;
			busy_b       <= next_busy_b;
			busy_e       <= next_busy_e;
			fetch_take   <= next_take;
			issue_slot   <= next_issue;
			arch_written <= next_arch;
		end
	end

	// ************************************************************
	// small direct-mapped cache tag store
	// ************************************************************
	logic [TAG_W-1:0]   tags [LINES];
	sap_line_t          state [LINES];
	logic [IDX_W-1:0]   idx;
	logic [TAG_W-1:0]   tag;
	logic               hit;
	sap_mstate_t        ms;
	sap_mstate_t        next_ms;
	logic [ADDR_W-1:0]  next_addr;
	logic               next_blk;
	logic               next_wb;
	logic               next_unc;
	logic               next_unc_wr;
	logic [1:0]         next_size;
	logic               next_ack;
	logic               next_nack;
	logic               next_fill;
	logic               fill;
	logic               refused;
	logic               next_refused;
	logic [1:0]         next_lso;

	assign idx = mem_addr[6 +: IDX_W];
	assign tag = mem_addr[ADDR_W-1 -: TAG_W];
	assign hit = (state[idx] != SAP_LS_INVALID) && (tags[idx] == tag);

	// memory sequencing; speculation does not gate cached misses at all,
	// the agent sees any address and must filter it itself (nack)
	always_comb begin
		next_ms      = ms;
		next_addr    = ext_addr;
		next_blk     = 1'b0;
		next_wb      = 1'b0;
		next_unc     = 1'b0;
		next_unc_wr  = ext_unc_wr;
		next_size    = ext_size;
		next_ack     = 1'b0;
		next_nack    = 1'b0;
		next_fill    = 1'b0;
		next_refused = refused;
		next_lso     = line_state_out;
		case (ms)
			SAP_MS_IDLE: begin
				if (mem_req && mem_uncached) begin
					// uncached waits until the access is no longer speculative
					if (!mem_spec) begin
						next_ms     = SAP_MS_UNC;
						next_unc    = 1'b1;
						next_unc_wr = mem_is_store;
						next_size   = 2'(mem_size);
						next_addr   = mem_addr;
					end
				end else if (mem_req && hit) begin
					next_ack = 1'b1;
					next_lso = 2'(state[idx]);
				end else if (mem_req && state[idx] == SAP_LS_DIRTY) begin
					// victim write-back, including lines dirtied by aborted stores
					next_ms   = SAP_MS_WBACK;
					next_wb   = 1'b1;
					next_addr = {tags[idx], idx, 6'h00};
				end else if (mem_req) begin
					next_ms   = SAP_MS_READ;
					next_blk  = 1'b1;
					next_addr = {mem_addr[ADDR_W-1:6], 6'h00};
				end
			end
			SAP_MS_WBACK: begin
				if (ext_done) begin
					next_ms   = SAP_MS_READ;
					next_blk  = 1'b1;
					next_addr = {mem_addr[ADDR_W-1:6], 6'h00};
				end
			end
			SAP_MS_READ: begin
				if (ext_nack) begin
					// refusal leaves the cache untouched
					next_ms      = SAP_MS_DONE;
					next_refused = 1'b1;
				end else if (ext_done) begin
					next_ms      = SAP_MS_DONE;
					next_fill    = 1'b1;
					next_refused = 1'b0;
				end
			end
			SAP_MS_UNC: begin
				if (ext_done || ext_nack) begin
					next_ms      = SAP_MS_DONE;
					next_refused = ext_nack;
				end
			end
			SAP_MS_DONE: begin
				next_ms   = SAP_MS_IDLE;
				next_ack  = !refused;
				next_nack = refused;
			end
			default: next_ms = SAP_MS_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ms             <= SAP_MS_IDLE;
			ext_addr       <= '0;
			ext_blk_rd     <= 1'b0;
			ext_wback      <= 1'b0;
			ext_unc        <= 1'b0;
			ext_unc_wr     <= 1'b0;
			ext_size       <= 2'h0;
			mem_ack        <= 1'b0;
			mem_nack       <= 1'b0;
			fill           <= 1'b0;
			refused        <= 1'b0;
			line_state_out <= 2'h0;
		end else begin
			ms             <= next_ms;
			ext_addr       <= next_addr;
			ext_blk_rd     <= next_blk;
			ext_wback      <= next_wb;
			ext_unc        <= next_unc;
			ext_unc_wr     <= next_unc_wr;
			ext_size       <= next_size;
			mem_ack        <= next_ack;
			mem_nack       <= next_nack;
			fill           <= next_fill;
			refused        <= next_refused;
			line_state_out <= next_lso;
		end
	end

	// line update on refill and on non-speculative store hit; spec_abort deliberately does not touch this array,
	// which is cheaper than checkpointing tags and is harmless when coherent
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			for (int i = 0; i < LINES; i++) begin
				state[i] <= SAP_LS_INVALID;
				tags[i]  <= '0;
			end
		end else if (fill) begin
			tags[idx] <= tag;
			if (mem_is_store)
				state[idx] <= SAP_LS_DIRTY;
			else
				state[idx] <= SAP_LS_CLEAN_EXCL;
		end else if (next_ack && ms == SAP_MS_IDLE && mem_is_store && !mem_spec) begin
			state[idx] <= SAP_LS_DIRTY;
		end
	end

endmodule

`default_nettype wire

//--- rtl/sap_pkg.sv
package sap_pkg;

	// ************************************************************
	// widths and limits
	// ************************************************************
	localparam int FETCH_MAX  = 4;
	localparam int ISSUE_MAX  = 5;
	localparam int NUM_SLOTS  = 5;
	localparam int ADDR_W     = 40;
	localparam int DATA_W     = 64;
	localparam int LINES      = 16;
	localparam int IDX_W      = 4;
	localparam int TAG_W      = ADDR_W - IDX_W - 6;
	localparam int NREGS      = 32;
	localparam int REG_W      = 5;

	// ************************************************************
	// repeat intervals of the unpipelined operations, in cycles
	// ************************************************************
	localparam logic [3:0] FDIV_INTERVAL = 4'hC;
	localparam logic [3:0] FSQRT_INTERVAL = 4'hE;
	localparam logic [3:0] IMUL_INTERVAL = 4'h6;
	localparam logic [3:0] IDIV_INTERVAL = 4'hF;
	localparam logic [3:0] BUSY_RESET    = 4'h0;

	// ************************************************************
	// instruction classes
	// ************************************************************
	typedef enum logic [3:0] {
		SAP_OP_NONE  = 4'h0,
		SAP_OP_FADD  = 4'h1,
		SAP_OP_FMUL  = 4'h2,
		SAP_OP_FDIV  = 4'h3,
		SAP_OP_FSQRT = 4'h4,
		SAP_OP_LOAD  = 4'h5,
		SAP_OP_STORE = 4'h6,
		SAP_OP_ADD   = 4'h7,
		SAP_OP_SHIFT = 4'h8,
		SAP_OP_BRANCH = 4'h9,
		SAP_OP_LOGIC = 4'hA,
		SAP_OP_IMUL  = 4'hB,
		SAP_OP_IDIV  = 4'hC
	} sap_op_t;

	// slot indices
	localparam int SLOT_A = 0;
	localparam int SLOT_B = 1;
	localparam int SLOT_C = 2;
	localparam int SLOT_D = 3;
	localparam int SLOT_E = 4;

	// cache line states
	typedef enum logic [1:0] {
		SAP_LS_INVALID = 2'h0,
		SAP_LS_SHARED  = 2'h1,
		SAP_LS_CLEAN_EXCL = 2'h2,
		SAP_LS_DIRTY   = 2'h3
	} sap_line_t;

	// uncached transfer sizes
	typedef enum logic [1:0] {
		SAP_SZ_PARTIAL = 2'h0,
		SAP_SZ_WORD    = 2'h1,
		SAP_SZ_DOUBLE  = 2'h2
	} sap_size_t;

	// memory side state machine
	typedef enum logic [2:0] {
		SAP_MS_IDLE    = 3'h0,
		SAP_MS_WBACK   = 3'h1,
		SAP_MS_READ    = 3'h2,
		SAP_MS_UNC     = 3'h3,
		SAP_MS_DONE    = 3'h4
	} sap_mstate_t;

endpackage

//--- rtl/sap_slot_sel.sv
`timescale 1ns/10ps
`default_nettype none

// picks, for one issue slot, the oldest ready candidate among the fetch group
module sap_slot_sel
	import sap_pkg::*;
#(
	parameter int SLOT = 0
) (
	input  wire logic [FETCH_MAX*4-1:0] ops,
	input  wire logic [FETCH_MAX-1:0]   ready,
	input  wire logic                   unit_free,
	output logic                        take,
	output logic [1:0]                  which
);

	// ************************************************************
	// class to slot mapping
	// ************************************************************
	function automatic logic fits(input sap_op_t op);
		case (SLOT)
			SLOT_A:  fits = (op == SAP_OP_FADD);
			SLOT_B:  fits = (op == SAP_OP_FMUL) || (op == SAP_OP_FDIV) || (op == SAP_OP_FSQRT);
			SLOT_C:  fits = (op == SAP_OP_LOAD) || (op == SAP_OP_STORE);
			SLOT_D:  fits = (op == SAP_OP_ADD) || (op == SAP_OP_SHIFT) || (op == SAP_OP_BRANCH)
				|| (op == SAP_OP_LOGIC);
			default: fits = (op == SAP_OP_ADD) || (op == SAP_OP_LOGIC) || (op == SAP_OP_IMUL)
				|| (op == SAP_OP_IDIV);
		endcase
	endfunction

	// lowest index wins so program order is kept inside a slot
	always_comb begin
		take  = 1'b0;
		which = 2'h0;
		for (int i = FETCH_MAX - 1; i >= 0; i--) begin
			if (ready[i] && unit_free && fits(sap_op_t'(ops[i*4 +: 4]))) begin
				take  = 1'b1;
				which = 2'(i);
			end
		end
	end

endmodule

`default_nettype wire

//--- verification/sap_agent.sv
`timescale 1ns/10ps
`default_nettype none
// far-side agent: answers every request after a chosen delay, refuses block reads on demand
module sap_agent (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       ext_blk_rd,
	input  wire logic       ext_wback,
	input  wire logic       ext_unc,
	input  wire logic       nack_en,
	input  wire logic [2:0] dly,
	output logic            ext_done,
	output logic            ext_nack
);
	logic nk;

	initial begin
		ext_done = 1'b0;
		ext_nack = 1'b0;
	end

	// sample on the falling edge so the registered pulse has settled; any address is served
	always @(negedge clk_sys) begin
		if (rst_n && (ext_blk_rd || ext_wback || ext_unc)) begin
			nk = ext_blk_rd && nack_en;
			repeat (dly) @(posedge clk_sys);
			#1;
			ext_done = !nk;
			ext_nack = nk;
			@(posedge clk_sys);
			#1;
			ext_done = 1'b0;
			ext_nack = 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- verification/sap_core_bench.sv
`timescale 1ns/10ps
`default_nettype none
module sap_core_bench
	import sap_pkg::*;
;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  fetch_valid, fetch_take, sn, ivl [4];
	logic [15:0] fetch_op, ops;
	logic [19:0] fetch_dst, fetch_src;
	logic [4:0]  done_valid, done_spec, issue_slot, s, al;
	logic [24:0] done_dst;
	logic [31:0] arch_written, r, lfsr = 32'h82C6;
	logic        spec_abort, spec_commit, mem_req, mem_is_fetch, mem_is_store, mem_spec, mem_uncached;
	logic        mem_ack, mem_nack, ext_blk_rd, ext_wback, ext_unc, ext_unc_wr, ext_done, ext_nack, nack_en;
	logic [1:0]  ext_size, line_state_out;
	logic [39:0] mem_addr, ext_addr;
	logic [2:0]  ag_dly;
	sap_size_t   mem_size;
	sap_op_t     lng [4];
	int          errors = 0, n_tests = 0, g;

	sap_core dut (.clk_sys, .rst_n, .fetch_valid, .fetch_op, .fetch_dst, .fetch_src, .fetch_take, .done_valid,
		.done_dst, .done_spec, .spec_abort, .spec_commit, .issue_slot, .arch_written, .mem_req, .mem_is_fetch,
		.mem_is_store, .mem_spec, .mem_uncached, .mem_size, .mem_addr, .mem_ack, .mem_nack, .ext_blk_rd,
		.ext_wback, .ext_unc, .ext_unc_wr, .ext_size, .ext_addr, .ext_done, .ext_nack, .line_state_out);
	sap_agent agent (.clk_sys, .rst_n, .ext_blk_rd, .ext_wback, .ext_unc, .nack_en, .dly(ag_dly), .ext_done,
		.ext_nack);

	// 200 MHz
	always #2.5 clk_sys = ~clk_sys;

	// a hang still ends in the verdict
	initial begin
		#100000;
		errors++;
		print_verdict();
	end

	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction

	// slots a class may go to; add and logic have two homes
	function automatic logic [4:0] slot_mask(input logic [3:0] op);
		case (op)
			SAP_OP_FADD: return 5'h1;
			SAP_OP_FMUL, SAP_OP_FDIV, SAP_OP_FSQRT: return 5'h2;
			SAP_OP_LOAD, SAP_OP_STORE: return 5'h4;
			SAP_OP_SHIFT, SAP_OP_BRANCH: return 5'h8;
			SAP_OP_ADD, SAP_OP_LOGIC: return 5'h18;
			default: return 5'h10;
		endcase
	endfunction

	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic print_verdict();
		if (errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask

	// one lane held until taken; gap counts cycles, sl the slot used
	task automatic iss(input logic [3:0] op, input logic [4:0] d, output int gap, output logic [4:0] sl);
		fetch_valid = 4'h1;
		fetch_op = {12'h0, op};
		fetch_dst = {15'h0, d};
		fetch_src = '0;
		gap = 0;
		do begin
			tick();
			gap++;
		end while (fetch_take[0] !== 1'b1 && gap < 40);
		sl = issue_slot;
		fetch_valid = '0;
		tick();
	endtask

	task automatic done(input logic [4:0] sl, input logic [4:0] d, input logic sp);
		done_valid = sl;
		done_dst = {5{d}};
		done_spec = {5{sp}};
		tick();
		done_valid = '0;
		check("arch write", arch_written[d], !sp);
	endtask

	task automatic abort();
		spec_abort = 1'b1;
		tick();
		spec_abort = 1'b0;
		tick();
	endtask

	// kind is {fetch, store, spec, uncached}; seen is {nack, uncached, writeback, block read}
	task automatic mem(input logic [3:0] kind, input logic [1:0] sz, input logic [39:0] a, output logic [3:0] sv);
		{mem_is_fetch, mem_is_store, mem_spec, mem_uncached} = kind;
		mem_size = sap_size_t'(sz);
		mem_addr = a;
		mem_req = 1'b1;
		sv = '0;
		for (int c = 0; c < 60; c++) begin
			tick();
			sv |= {mem_nack, ext_unc, ext_wback, ext_blk_rd};
			if (ext_blk_rd)
				check("block addr", ext_addr[39:6], a[39:6]);
			if (c == 9 && kind[1:0] == 2'h3) begin
				check("spec uncached held", {sv, mem_ack}, 5'h0);
				mem_spec = 1'b0;
			end
			if (mem_ack || mem_nack)
				break;
		end
		check("answered", mem_ack | mem_nack, 1'b1);
		mem_req = 1'b0;
		tick();
	endtask

	initial begin
		{fetch_valid, fetch_op, fetch_dst, fetch_src, done_valid, done_dst, done_spec} = '0;
		{spec_abort, spec_commit, mem_req, mem_is_fetch, mem_is_store, mem_spec, mem_uncached, nack_en} = '0;
		mem_size = SAP_SZ_DOUBLE;
		mem_addr = '0;
		ag_dly = 3'h1;
		lng = '{SAP_OP_FDIV, SAP_OP_FSQRT, SAP_OP_IMUL, SAP_OP_IDIV};
		ivl = '{FDIV_INTERVAL, FSQRT_INTERVAL, IMUL_INTERVAL, IDIV_INTERVAL};
		repeat (4) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		check("reset outputs", {fetch_take, issue_slot, arch_written, mem_ack, ext_blk_rd}, 0);
		// every class to its own slot, odd ones retired speculatively
		for (int k = 1; k <= 12; k++) begin
			iss(k[3:0], k[4:0], g, s);
			check("slot map", (s & ~slot_mask(k[3:0])) == 0 && $countones(s) == 1, 1'b1);
			done(s, k[4:0], k[0]);
			abort();
			repeat (16) tick();
		end
		// unpipelined units refuse a restart for their interval
		for (int k = 0; k < 4; k++) begin
			iss(lng[k], 5'h14, g, s);
			iss(k < 2 ? SAP_OP_FMUL : SAP_OP_IMUL, 5'h15, g, s);
			check("repeat gap", g >= ivl[k] - 1 && g <= ivl[k] + 2, 1'b1);
			abort();
		end
		// full fetch group of independent work, then a dependent pair
		fetch_valid = 4'hF;
		fetch_op = {SAP_OP_SHIFT, SAP_OP_LOAD, SAP_OP_FMUL, SAP_OP_FADD};
		fetch_dst = {5'h9, 5'h8, 5'h7, 5'h6};
		tick();
		check("four wide", {fetch_take, issue_slot}, {4'hF, 5'hF});
		// withdraw the group first, or it issues again once the abort clears the scoreboard
		fetch_valid = '0;
		abort();
		fetch_op = {8'h0, SAP_OP_SHIFT, SAP_OP_ADD};
		fetch_dst = {10'h0, 5'h4, 5'h3};
		fetch_src = {10'h0, 5'h3, 5'h0};
		fetch_valid = 4'h3;
		tick();
		check("dependent held", fetch_take, 4'h1);
		s = issue_slot;
		fetch_valid = 4'h2;
		tick();
		check("still pending", fetch_take, 4'h0);
		done(s, 5'h3, 1'b0);
		tick();
		check("operand ready", fetch_take, 4'h2);
		// add and logic side by side fill both integer slots
		fetch_op = {8'h0, SAP_OP_LOGIC, SAP_OP_ADD};
		fetch_dst = {10'h0, 5'h0B, 5'h0A};
		fetch_src = '0;
		fetch_valid = 4'h3;
		tick();
		check("two integer slots", {fetch_take, issue_slot}, {4'h3, 5'h18});
		fetch_valid = '0;
		abort();
		// a committed speculative result lands, one aborted in the same cycle does not
		for (int k = 0; k < 2; k++) begin
			{spec_commit, spec_abort, done_valid, done_dst, done_spec} = {1'b1, k[0], 5'h01, {5{5'h11}}, 5'h1F};
			tick();
			{spec_commit, spec_abort, done_valid} = '0;
			check("committed write", arch_written[17], !k[0]);
		end
		// random groups
		repeat (12) begin
			r = rnd();
			for (int i = 0; i < 4; i++)
				ops[i*4+:4] = 4'(r[i*4+:4] % 12 + 1);
			fetch_valid = r[19:16];
			fetch_op = ops;
			fetch_dst = {5'h1C, 5'h1B, 5'h1A, 5'h19};
			fetch_src = r[31:12];
			tick();
			fetch_valid = '0;
			al = '0;
			for (int i = 0; i < 4; i++)
				if (fetch_take[i])
					al |= slot_mask(ops[i*4+:4]);
			check("random slots", {fetch_take & ~r[19:16], issue_slot & ~al}, 0);
			abort();
			repeat (14) tick();
		end
		// speculative fetch miss fills and keeps clean exclusive past an abort
		mem(4'hA, 2'h2, 40'h12_3456_7040, sn);
		check("fetch miss", sn, 4'h1);
		abort();
		mem(4'hA, 2'h2, 40'h12_3456_7040, sn);
		check("fetch kept", {sn, line_state_out}, {4'h0, SAP_LS_CLEAN_EXCL});
		// speculative store miss leaves a dirty line that is later written back
		mem(4'h6, 2'h2, 40'h00_0000_2080, sn);
		check("store miss", sn, 4'h1);
		abort();
		mem(4'h2, 2'h2, 40'h00_0000_2080, sn);
		check("store dirty", {sn, line_state_out}, {4'h0, SAP_LS_DIRTY});
		mem(4'h0, 2'h2, 40'h00_0004_2080, sn);
		check("victim written", sn, 4'h3);
		// refused block read
		nack_en = 1'b1;
		mem(4'h2, 2'h2, 40'hFF_0000_00C0, sn);
		check("refused", sn, 4'h9);
		nack_en = 1'b0;
		// uncached sizes, each first held back while speculative
		for (int k = 0; k < 3; k++) begin
			mem({1'b0, k[0], 2'h3}, k[1:0], 40'h00_1000_0010, sn);
			check("uncached", {sn, ext_size, ext_unc_wr}, {4'h4, k[1:0], k[0]});
		end
		// random cached traffic at any address, slow and prompt answers
		repeat (12) begin
			r = rnd();
			ag_dly = 3'(r[1:0]) + 3'h1;
			mem({1'b0, r[2], r[3], 1'b0}, 2'h2, {8'h0, r}, sn);
			check("random access", sn[3:2], 2'h0);
		end
		print_verdict();
	end
endmodule
`default_nettype wire

//--- verification/sap_core_sva.sv
`timescale 1ns/10ps
`default_nettype none
module sap_core_sva
	import sap_pkg::*;
(
	input wire logic                   clk_sys,
	input wire logic                   rst_n,
	input wire logic [FETCH_MAX*4-1:0] fetch_op,
	input wire logic [FETCH_MAX-1:0]   fetch_take,
	input wire logic [NUM_SLOTS-1:0]   issue_slot,
	input wire logic [NUM_SLOTS-1:0]   done_valid,
	input wire logic [NUM_SLOTS-1:0]   done_spec,
	input wire logic                   spec_abort,
	input wire logic [NREGS-1:0]       arch_written,
	input wire logic                   mem_req,
	input wire logic                   mem_spec,
	input wire logic                   mem_uncached,
	input wire logic                   mem_ack,
	input wire logic                   mem_nack,
	input wire logic                   ext_blk_rd,
	input wire logic                   ext_unc,
	input wire logic [1:0]             ext_size,
	input wire logic                   ext_done,
	input wire logic                   ext_nack
);
	logic [15:0] prev_op;
	logic        rd_pend;
	logic        b_long;
	logic        e_mul;

	// fetch_take names lanes of the previous cycle, so keep that cycle's ops
	always_ff @(posedge clk_sys) begin
		prev_op <= fetch_op;
		rd_pend <= (!rst_n || ext_done || ext_nack) ? 1'b0 : (rd_pend || ext_blk_rd);
	end

	// which long-latency class just went out
	always_comb begin
		b_long = 1'b0;
		e_mul = 1'b0;
		for (int i = 0; i < 4; i++) begin
			b_long |= fetch_take[i] && (prev_op[i*4+:4] inside {SAP_OP_FDIV, SAP_OP_FSQRT});
			e_mul |= fetch_take[i] && (prev_op[i*4+:4] inside {SAP_OP_IMUL, SAP_OP_IDIV});
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	take_count_a: assert property ($countones(fetch_take) == $countones(issue_slot))
		else $error("issued lanes and busy slots differ");
	fdiv_gap_a: assert property (b_long |=> !issue_slot[SLOT_B] [*8])
		else $error("slot B restarted too soon");
	imul_gap_a: assert property (e_mul |=> !issue_slot[SLOT_E] [*4])
		else $error("slot E restarted too soon");
	fill_ack_a: assert property (rd_pend && ext_done |-> ##2 mem_ack)
		else $error("no ack two cycles after fill");
	blk_cached_a: assert property (ext_blk_rd |-> mem_req && !mem_uncached)
		else $error("block read for uncached access");
	nack_pass_a: assert property (rd_pend && ext_nack |-> ##[1:2] mem_nack)
		else $error("refusal not passed back");
	spec_unc_a: assert property (mem_req && mem_uncached && mem_spec |=> !ext_unc)
		else $error("speculative uncached issued");
	unc_size_a: assert property (ext_unc |-> !ext_blk_rd && ext_size != 2'h3)
		else $error("uncached transfer of block size");
	abort_arch_a: assert property (spec_abort && (done_valid & ~done_spec) == '0 |=> arch_written == '0)
		else $error("aborted result reached registers");
	reset_quiet_a: assert property (@(posedge clk_sys) disable iff (1'b0)
		!rst_n |=> issue_slot == '0 && !mem_ack && !ext_blk_rd)
		else $error("outputs active after reset");

	// main scenarios reached
	fill_c: cover property (rd_pend && ext_done);
	long_c: cover property (b_long);
	nack_c: cover property (mem_nack);
endmodule

bind sap_core sap_core_sva chk (.clk_sys, .rst_n, .fetch_op, .fetch_take, .issue_slot, .done_valid, .done_spec,
	.spec_abort, .arch_written, .mem_req, .mem_spec, .mem_uncached, .mem_ack, .mem_nack, .ext_blk_rd, .ext_unc,
	.ext_size, .ext_done, .ext_nack);
`default_nettype wire
